// ==== shared/dbar_pkg.sv ====
// Shared constants and types for the debug bus access router
package dbar_pkg;
  // Debug register addresses
  localparam logic [31:0] DEBUG_FAULT_STATUS_ADDR = 32'hE000ED30;
  localparam logic [31:0] DEBUG_HALT_CONTROL_STATUS_ADDR = 32'hE000EDF0;
  localparam logic [31:0] CORE_REGISTER_SELECTOR_ADDR = 32'hE000EDF4;
  localparam logic [31:0] CORE_REGISTER_DATA_ADDR = 32'hE000EDF8;
  localparam logic [31:0] EXCEPTION_MONITOR_CONTROL_ADDR = 32'hE000EDFC;
  localparam logic [31:0] DEBUG_AUTHENTICATION_CONTROL_ADDR = 32'hE000EE04;
  localparam logic [31:0] DEBUG_SECURITY_CONTROL_STATUS_ADDR = 32'hE000EE08;
  localparam logic [31:0] DEBUG_AUTHENTICATION_STATUS_ADDR = 32'hE000EFB8;
  // Reset values
  localparam logic [31:0] REG_ZERO_RST = 32'h00000000;
  localparam logic [31:0] DEBUG_SECURITY_CONTROL_STATUS_RST = 32'h00030000;
  // Field positions
  localparam int SECURE_DEBUG_ENABLE_BIT = 16;
  localparam int SECURE_UNPRIV_DEBUG_ENABLE_BIT = 24;
  localparam int NONSECURE_UNPRIV_DEBUG_ENABLE_BIT = 25;
  localparam int UNPRIV_PORT_ACCESS_ENABLE_BIT = 0;
  // Address map
  localparam logic [31:0] PPB_BASE = 32'hE0000000;
  localparam logic [31:0] PPB_LAST = 32'hE00FFFFF;
  localparam logic [31:0] EXTERNAL_PRIVATE_PERIPHERAL_BUS_BASE = 32'hE0040000;
  localparam logic [31:0] EXTERNAL_PRIVATE_PERIPHERAL_BUS_LAST = 32'hE00FEFFF;
  localparam logic [19:0] MEMTEST_PAGE = 20'hE0046;
  localparam logic [19:0] WAKEUP_PAGE = 20'hE0047;
  localparam logic [19:0] SELFTEST_PAGE = 20'hE0048;
  localparam logic [31:0] INSTRUCTION_TIGHTLY_COUPLED_MEMORY_BASE = 32'h00000000;
  localparam logic [31:0] INSTRUCTION_TIGHTLY_COUPLED_MEMORY_LAST = 32'h00FFFFFF;
  localparam logic [31:0] DATA_TIGHTLY_COUPLED_MEMORY_BASE = 32'h20000000;
  localparam logic [31:0] DATA_TIGHTLY_COUPLED_MEMORY_LAST = 32'h20FFFFFF;
  localparam logic [31:0] PAHB_BASE = 32'h40000000;
  localparam logic [31:0] PAHB_LAST = 32'h5FFFFFFF;
  // Request protection bit positions
  localparam int PROT_DATA = 0;
  localparam int PROT_PRIV = 1;
  localparam int PROT_BUFF = 2;
  localparam int PROT_MOD = 3;
  localparam int PROT_LOOKUP = 4;
  localparam int PROT_SHARE = 6;
  // Number of request/response style targets
  localparam int NUM_FWD = 5;
  // Routing targets; the first five index the forwarded ports
  typedef enum logic [2:0] {
    TGT_INSTRUCTION_TIGHTLY_COUPLED_MEMORY = 3'h0,
    TGT_DATA_TIGHTLY_COUPLED_MEMORY = 3'h1,
    TGT_MAIN = 3'h2,
    TGT_PAHB = 3'h3,
    TGT_INTERNAL_PRIVATE_PERIPHERAL_SPACE = 3'h4,
    TGT_EXTERNAL_PRIVATE_PERIPHERAL_BUS = 3'h5,
    TGT_REGS = 3'h6
  } dbar_tgt_t;
  // Downstream request, shared by all targets
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic write;
    logic [2:0] size;
  } dbar_dreq_t;
  // Downstream response of one target
  typedef struct packed {
    logic ready;
    logic err;
    logic [31:0] rdata;
  } dbar_drsp_t;
endpackage : dbar_pkg

// ==== hw/dbar_apb_seq.sv ====
// APB transfer sequencer for the external private peripheral bus
module dbar_apb_seq (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Transfer request and completion
  input wire logic start_i,
  output logic done_o,
  output logic err_o,
  output logic [31:0] rdata_o,
  // APB requester pins
  output logic psel_o,
  output logic penable_o,
  input wire logic pready_i,
  input wire logic [31:0] prdata_i,
  input wire logic pslverr_i
);
  import dbar_pkg::*;

  // Setup phase, then access phase held until the completer is ready
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      psel_o <= 1'h0;
      penable_o <= 1'h0;
    end else if (start_i) begin
      psel_o <= 1'h1;
      penable_o <= 1'h0;
    end else if (psel_o && !penable_o) begin
      penable_o <= 1'h1;
    end else if (penable_o && pready_i) begin
      psel_o <= 1'h0;
      penable_o <= 1'h0;
    end
  end

  // Completion on the ready edge; the router captures the data
  assign done_o = penable_o & pready_i;
  assign err_o = done_o & pslverr_i;
  assign rdata_o = prdata_i;
endmodule : dbar_apb_seq

// ==== hw/dbar_router.sv ====
// Debug access router: debug AHB slave, address decode, attributes, cache lookup

module dbar_router #(
  parameter bit DCACHE_PRESENT = 1'b1,
  parameter bit SECURITY_EXT = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Debug AHB slave port
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [6:0] debug_request_protection_i,
  input wire logic debug_nonsecure_request_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hready_o,
  output logic debug_port_response_o,
  // Access control pin
  input wire logic secure_debug_allowed_i,
  // Attribution and protection unit lookup
  output logic [31:0] lookup_addr_o,
  output logic mpu_unpriv_check_o,
  output logic mpu_secure_regions_o,
  input wire logic mpu_allow_i,
  input wire logic sau_secure_i,
  // Data cache lookup
  output logic cache_lookup_o,
  output logic cache_update_o,
  input wire logic cache_hit_i,
  input wire logic [31:0] cache_rdata_i,
  // Forwarded targets: TCMs, main, peripheral port, internal space
  output dbar_pkg::dbar_dreq_t fwd_req_o,
  output logic [dbar_pkg::NUM_FWD-1:0] fwd_valid_o,
  input wire dbar_pkg::dbar_drsp_t [dbar_pkg::NUM_FWD-1:0] fwd_rsp_i,
  // Target attributes
  output logic instr_tcm_privilege_out_o,
  output logic data_tcm_privilege_out_o,
  output logic instr_tcm_debugger_flag_o,
  output logic data_tcm_debugger_flag_o,
  output logic [2:0] main_prot_o,
  output logic [3:0] main_cache_o,
  output logic read_debugger_flag_o,
  output logic write_debugger_flag_o,
  output logic [6:0] peripheral_port_protection_o,
  output logic peripheral_port_debugger_flag_o,
  output logic internal_private_peripheral_space_privileged_o,
  output logic internal_private_peripheral_space_debugger_bit_o,
  // External private peripheral APB
  output logic psel_o,
  output logic penable_o,
  output logic [2:0] pprot_o,
  output logic apb_debugger_address_bit_o,
  input wire logic pready_i,
  input wire logic [31:0] prdata_i,
  input wire logic pslverr_i
);
  import dbar_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_DATA = 3'h1,
    S_CACHE = 3'h2,
    S_FWD = 3'h3,
    S_APB = 3'h4,
    S_ERR1 = 3'h5,
    S_ERR2 = 3'h6
  } dbar_state_t;

  dbar_state_t state;
  dbar_state_t next_state;
  dbar_tgt_t route;
  logic [6:0] prot;
  logic nonsec;
  logic allow_meta;
  logic allow_sync;
  logic [31:0] fault_status;
  logic [31:0] halt_ctl;
  logic [31:0] core_sel;
  logic [31:0] core_data;
  logic [31:0] exc_mon;
  logic [31:0] auth_ctl;
  logic [31:0] sec_ctl;
  logic [31:0] reg_rdata;
  logic secure_debug_enable, sec_req, unpriv_dbg, eff_priv, unpriv_port_access_enable;
  logic in_special, is_mem, deny, lookup_ok, write_thru;
  logic accept, apb_start, apb_done, apb_err, fwd_done;
  logic [31:0] apb_rdata;
  logic [2:0] idx;
  logic unpriv_q;

  // Address decode, used for routing at the address phase
  function automatic dbar_tgt_t decode(input logic [31:0] a);
    if (a >= INSTRUCTION_TIGHTLY_COUPLED_MEMORY_BASE && a <= INSTRUCTION_TIGHTLY_COUPLED_MEMORY_LAST) return TGT_INSTRUCTION_TIGHTLY_COUPLED_MEMORY;
    if (a >= DATA_TIGHTLY_COUPLED_MEMORY_BASE && a <= DATA_TIGHTLY_COUPLED_MEMORY_LAST) return TGT_DATA_TIGHTLY_COUPLED_MEMORY;
    if (a >= PAHB_BASE && a <= PAHB_LAST) return TGT_PAHB;
    if (a >= EXTERNAL_PRIVATE_PERIPHERAL_BUS_BASE && a <= EXTERNAL_PRIVATE_PERIPHERAL_BUS_LAST) return TGT_EXTERNAL_PRIVATE_PERIPHERAL_BUS;
    if (a == DEBUG_FAULT_STATUS_ADDR || a == DEBUG_AUTHENTICATION_STATUS_ADDR ||
        (a >= DEBUG_HALT_CONTROL_STATUS_ADDR && a <= DEBUG_SECURITY_CONTROL_STATUS_ADDR)) return TGT_REGS;
    if (a >= PPB_BASE && a <= PPB_LAST) return TGT_INTERNAL_PRIVATE_PERIPHERAL_SPACE;
    return TGT_MAIN;
  endfunction : decode

  // Access control pin comes from outside, so two flops first
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      allow_meta <= 1'h0;
      allow_sync <= 1'h0;
    end else begin
      allow_meta <= secure_debug_allowed_i;
      allow_sync <= allow_meta;
    end
  end

  // Security and privilege of the held request
  assign secure_debug_enable = SECURITY_EXT & allow_sync;
  assign sec_req = secure_debug_enable & ~nonsec;
  assign unpriv_dbg = sec_req ? halt_ctl[SECURE_UNPRIV_DEBUG_ENABLE_BIT]
                              : halt_ctl[NONSECURE_UNPRIV_DEBUG_ENABLE_BIT];
  assign eff_priv = prot[PROT_PRIV] & ~unpriv_dbg;
  assign unpriv_port_access_enable = auth_ctl[UNPRIV_PORT_ACCESS_ENABLE_BIT];
  assign in_special = route == TGT_EXTERNAL_PRIVATE_PERIPHERAL_BUS && (fwd_req_o.addr[31:12] == MEMTEST_PAGE ||
    fwd_req_o.addr[31:12] == WAKEUP_PAGE || fwd_req_o.addr[31:12] == SELFTEST_PAGE);
  assign is_mem = route == TGT_INSTRUCTION_TIGHTLY_COUPLED_MEMORY || route == TGT_DATA_TIGHTLY_COUPLED_MEMORY || route == TGT_MAIN || route == TGT_PAHB;

  // Refusal: attribution, protection unit, privilege on peripheral spaces
  always_comb begin
    deny = 1'h0;
    if (in_special) begin
      deny = ~(eff_priv & sec_req);
    end else if (route == TGT_EXTERNAL_PRIVATE_PERIPHERAL_BUS) begin
      deny = (~eff_priv & ~unpriv_port_access_enable) | (sau_secure_i & ~sec_req);
    end else if (route == TGT_REGS || route == TGT_INTERNAL_PRIVATE_PERIPHERAL_SPACE) begin
      deny = ~eff_priv & ~unpriv_port_access_enable;
    end else if (is_mem) begin
      deny = (sau_secure_i & ~sec_req) | (unpriv_dbg & ~mpu_allow_i);
    end
  end

  // Normal cacheable, non-shareable, main-bound only; others bypass
  assign lookup_ok = DCACHE_PRESENT && route == TGT_MAIN && prot[PROT_MOD] &&
    prot[PROT_LOOKUP] && !prot[PROT_SHARE];
  assign write_thru = ~prot[PROT_BUFF];

  // Protection unit lookup runs on the held address
  assign lookup_addr_o = fwd_req_o.addr;
  assign mpu_unpriv_check_o = state == S_DATA && unpriv_dbg;
  assign mpu_secure_regions_o = sec_req;

  // AHB slave handshake; error response spans two cycles
  assign accept = hsel_i & htrans_i[1] & hready_o;
  assign hready_o = state == S_IDLE || state == S_ERR2;
  assign debug_port_response_o = state == S_ERR1 || state == S_ERR2;

  // Address phase capture; write data taken raw, no byte lane swap
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fwd_req_o <= '0;
      prot <= 7'h00;
      nonsec <= 1'h0;
      route <= TGT_MAIN;
    end else if (accept) begin
      fwd_req_o.addr <= haddr_i;
      fwd_req_o.write <= hwrite_i;
      fwd_req_o.size <= hsize_i;
      prot <= debug_request_protection_i;
      nonsec <= debug_nonsecure_request_i;
      route <= decode(haddr_i);
    end else if (state == S_DATA) begin
      fwd_req_o.wdata <= hwdata_i;
    end
  end

  // Sequencing of one transfer
  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE, S_ERR2: begin
        next_state = accept ? S_DATA : S_IDLE;
      end
      S_DATA: begin
        if (deny) begin
          next_state = S_ERR1;
        end else if (route == TGT_REGS) begin
          next_state = S_IDLE;
        end else if (route == TGT_EXTERNAL_PRIVATE_PERIPHERAL_BUS) begin
          next_state = S_APB;
        end else if (lookup_ok) begin
          next_state = S_CACHE;
        end else begin
          next_state = S_FWD;
        end
      end
      S_CACHE: begin
        if (!cache_hit_i) begin
          next_state = S_FWD;
        end else if (fwd_req_o.write && write_thru) begin
          next_state = S_FWD;
        end else begin
          next_state = S_IDLE;
        end
      end
      S_FWD: begin
        if (fwd_done) begin
          next_state = fwd_rsp_i[idx].err ? S_ERR1 : S_IDLE;
        end
      end
      S_APB: begin
        if (apb_done) begin
          next_state = apb_err ? S_ERR1 : S_IDLE;
        end
      end
      S_ERR1: begin
        next_state = S_ERR2;
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Forward strobes, one per request/response target
  assign idx = route;
  assign fwd_done = state == S_FWD && idx < 3'(NUM_FWD) && fwd_rsp_i[idx].ready;
  for (genvar g = 0; g < NUM_FWD; g++) begin : g_fwd
    assign fwd_valid_o[g] = state == S_FWD && route == dbar_tgt_t'(g);
  end

  // Cache lookup strobes; no allocate request exists on a miss
  assign cache_lookup_o = state == S_CACHE;
  assign cache_update_o = state == S_CACHE && cache_hit_i && fwd_req_o.write;

  // Attributes fixed at the decision point, held through the transfer
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      instr_tcm_privilege_out_o <= 1'h0;
      data_tcm_privilege_out_o <= 1'h0;
      main_prot_o <= 3'h0;
      main_cache_o <= 4'h0;
      peripheral_port_protection_o <= 7'h01;
      internal_private_peripheral_space_privileged_o <= 1'h0;
      pprot_o <= 3'h0;
      unpriv_q <= 1'h0;
    end else if (state == S_DATA) begin
      instr_tcm_privilege_out_o <= eff_priv;
      data_tcm_privilege_out_o <= eff_priv;
      main_prot_o <= {1'h0, ~sau_secure_i, eff_priv};
      main_cache_o <= prot[5:2];
      peripheral_port_protection_o <= {prot[6:2], eff_priv, 1'h1};
      internal_private_peripheral_space_privileged_o <= eff_priv;
      pprot_o <= {1'h0, ~sec_req, eff_priv};
      unpriv_q <= unpriv_dbg;
    end
  end

  // Debugger indicators follow the strobe of their own port
  assign instr_tcm_debugger_flag_o = fwd_valid_o[TGT_INSTRUCTION_TIGHTLY_COUPLED_MEMORY];
  assign data_tcm_debugger_flag_o = fwd_valid_o[TGT_DATA_TIGHTLY_COUPLED_MEMORY];
  assign read_debugger_flag_o = fwd_valid_o[TGT_MAIN] & ~fwd_req_o.write;
  assign write_debugger_flag_o = fwd_valid_o[TGT_MAIN] & fwd_req_o.write;
  assign peripheral_port_debugger_flag_o = fwd_valid_o[TGT_PAHB];
  assign internal_private_peripheral_space_debugger_bit_o = fwd_valid_o[TGT_INTERNAL_PRIVATE_PERIPHERAL_SPACE];
  assign apb_debugger_address_bit_o = psel_o;

  // External peripheral APB sequencer
  assign apb_start = state == S_DATA && next_state == S_APB;
  dbar_apb_seq u_apb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(apb_start),
    .done_o(apb_done),
    .err_o(apb_err),
    .rdata_o(apb_rdata),
    .psel_o(psel_o),
    .penable_o(penable_o),
    .pready_i(pready_i),
    .prdata_i(prdata_i),
    .pslverr_i(pslverr_i)
  );

  // Debug register read view; secure debug bit is live, not stored
  always_comb begin
    reg_rdata = REG_ZERO_RST;
    unique case (fwd_req_o.addr)
      DEBUG_FAULT_STATUS_ADDR: reg_rdata = fault_status;
      DEBUG_HALT_CONTROL_STATUS_ADDR: begin
        reg_rdata = halt_ctl;
        reg_rdata[SECURE_DEBUG_ENABLE_BIT] = secure_debug_enable;
      end
      CORE_REGISTER_DATA_ADDR: reg_rdata = core_data;
      EXCEPTION_MONITOR_CONTROL_ADDR: reg_rdata = exc_mon;
      DEBUG_AUTHENTICATION_CONTROL_ADDR: reg_rdata = auth_ctl;
      DEBUG_SECURITY_CONTROL_STATUS_ADDR: reg_rdata = sec_ctl;
      DEBUG_AUTHENTICATION_STATUS_ADDR: reg_rdata = {30'h0, secure_debug_enable, 1'h1};
      default: reg_rdata = REG_ZERO_RST;
    endcase
  end

  // Debug register writes, done in the data phase of an allowed access
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fault_status <= REG_ZERO_RST;
      halt_ctl <= REG_ZERO_RST;
      core_sel <= REG_ZERO_RST;
      core_data <= REG_ZERO_RST;
      exc_mon <= REG_ZERO_RST;
      auth_ctl <= REG_ZERO_RST;
      sec_ctl <= DEBUG_SECURITY_CONTROL_STATUS_RST;
    end else if (state == S_DATA && route == TGT_REGS && !deny && fwd_req_o.write) begin
      unique case (fwd_req_o.addr)
        DEBUG_FAULT_STATUS_ADDR: fault_status <= hwdata_i;
        DEBUG_HALT_CONTROL_STATUS_ADDR: halt_ctl <= hwdata_i;
        CORE_REGISTER_SELECTOR_ADDR: core_sel <= hwdata_i;
        CORE_REGISTER_DATA_ADDR: core_data <= hwdata_i;
        EXCEPTION_MONITOR_CONTROL_ADDR: exc_mon <= hwdata_i;
        DEBUG_AUTHENTICATION_CONTROL_ADDR: auth_ctl <= hwdata_i;
        DEBUG_SECURITY_CONTROL_STATUS_ADDR: sec_ctl <= hwdata_i;
        default: sec_ctl <= sec_ctl;
      endcase
    end
  end

  // Read data captured from whichever source completed, unswapped
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hrdata_o <= 32'h00000000;
    end else if (state == S_DATA && route == TGT_REGS) begin
      hrdata_o <= reg_rdata;
    end else if (state == S_CACHE && cache_hit_i) begin
      hrdata_o <= cache_rdata_i;
    end else if (fwd_done) begin
      hrdata_o <= fwd_rsp_i[idx].rdata;
    end else if (apb_done) begin
      hrdata_o <= apb_rdata;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  error_two_cycle_a: assert property (state == S_ERR1 |-> debug_port_response_o && !hready_o
    ##1 debug_port_response_o && hready_o) else $error("error response not two cycles");
  unpriv_tcm_a: assert property ((|fwd_valid_o[1:0]) && unpriv_q |->
    !instr_tcm_privilege_out_o && !data_tcm_privilege_out_o) else $error("tcm priv under unpriv");
  main_attr_a: assert property (fwd_valid_o[TGT_MAIN] |-> !main_prot_o[2] &&
    (read_debugger_flag_o ^ write_debugger_flag_o)) else $error("main attributes wrong");
  periph_prot_a: assert property (fwd_valid_o[TGT_PAHB] |->
    peripheral_port_protection_o[0] && peripheral_port_debugger_flag_o) else $error("pahb attr");
  test_window_a: assert property (state == S_DATA && in_special && !(eff_priv && sec_req) |=>
    state == S_ERR1 ##1 state == S_ERR2) else $error("test window not refused");
  sau_reject_a: assert property (state == S_DATA && is_mem && sau_secure_i && !sec_req |=>
    debug_port_response_o[*2]) else $error("attribution reject missed");
  hit_read_a: assert property (state == S_CACHE && cache_hit_i && !fwd_req_o.write |=>
    hready_o && fwd_valid_o == '0) else $error("hit read went to main");
  cache_bypass_a: assert property (state == S_DATA && !deny && route == TGT_MAIN && !lookup_ok |=>
    !cache_lookup_o ##1 !cache_lookup_o) else $error("bypass access looked up");
  apb_bit31_a: assert property ($rose(psel_o) |-> apb_debugger_address_bit_o ##1
    penable_o && apb_debugger_address_bit_o) else $error("apb debugger bit low");
  no_sde_a: assert property (!(SECURITY_EXT && allow_sync) |-> !secure_debug_enable && !sec_req) else $error("sde set");

  error_seen_c: cover property (state == S_ERR1 ##1 state == S_ERR2);
  cache_hit_c: cover property (cache_lookup_o && cache_hit_i);
  apb_done_c: cover property (apb_done && !apb_err);
  reg_write_c: cover property (state == S_DATA && route == TGT_REGS && fwd_req_o.write);
endmodule : dbar_router

// ==== verification/dbar_tgt_model.sv ====
// Model of the targets behind the router: memories, ports and an APB completer
module dbar_tgt_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Forwarded targets
  input wire logic [dbar_pkg::NUM_FWD-1:0] fwd_valid_i,
  input wire logic err_i,
  output dbar_pkg::dbar_drsp_t [dbar_pkg::NUM_FWD-1:0] fwd_rsp_o,
  // APB completer
  input wire logic psel_i,
  input wire logic penable_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import dbar_pkg::*;
  logic [NUM_FWD-1:0] seen;
  // One wait state per target, so the router must hold its request
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      seen <= '0;
    end else begin
      seen <= fwd_valid_i & ~seen;
    end
  end
  // Data inverts while not ready so a stale word never matches
  always_comb begin
    for (int i = 0; i < NUM_FWD; i++) begin
      fwd_rsp_o[i].ready = fwd_valid_i[i] & seen[i];
      fwd_rsp_o[i].err = err_i & seen[i];
      fwd_rsp_o[i].rdata = {28'hA5A5000, 4'(i)} ^ {32{~seen[i]}};
    end
  end
  // Prompt completer; its error line is commanded by the bench
  assign pready_o = penable_i;
  assign pslverr_o = err_i & penable_i;
  assign prdata_o = penable_i ? 32'hC0DE0001 : 32'h3F21FFFE;
endmodule : dbar_tgt_model

// ==== verification/debug_bus_access_router_tb_top.sv ====
// Self-checking bench for the debug bus access router
module debug_bus_access_router_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dbar_pkg::*;
  // Stimulus
  logic clk = 1'h0, rst = 1'h1, sel = 1'h0, hw = 1'h0, ns = 1'h0, mpa = 1'h1, security_attribution_unit = 1'h0, hit = 1'h0, te = 1'h0;
  logic sda = 1'h1;
  logic [31:0] ad = 32'h0, wd = 32'h0;
  logic [1:0] tr = 2'h0;
  logic [6:0] pr = 7'h0;
  // Design and model wires, snapshots, tallies
  logic [31:0] hr, prd, la;
  logic rdy, rsp, lk, up, ps, pe, prdy, perr, itp, dtp, itf, dtf, rf, wf, pf, ipf, ab, ms, mu, ipp;
  logic [6:0] pa, sfl, spa, smm;
  logic [3:0] mc;
  logic [2:0] pp, spp, mp;
  logic [1:0] stp;
  logic [4:0] fv;
  dbar_drsp_t [4:0] frs;
  dbar_dreq_t rq;
  int nm = 0, nl = 0, nu = 0, nx = 0, fails = 0, num_checks = 0;

  always #25 clk = ~clk;

  dbar_router #(.DCACHE_PRESENT(1'b1), .SECURITY_EXT(1'b1)) dut (
    .clk_i(clk), .rst_i(rst), .hsel_i(sel), .haddr_i(ad), .htrans_i(tr), .hwrite_i(hw), .hsize_i(3'h2),
    .debug_request_protection_i(pr), .debug_nonsecure_request_i(ns), .hwdata_i(wd), .hrdata_o(hr),
    .hready_o(rdy), .debug_port_response_o(rsp), .secure_debug_allowed_i(sda), .lookup_addr_o(la),
    .mpu_unpriv_check_o(mu), .mpu_secure_regions_o(ms), .mpu_allow_i(mpa), .sau_secure_i(security_attribution_unit),
    .cache_lookup_o(lk), .cache_update_o(up), .cache_hit_i(hit), .cache_rdata_i(32'h0CAC0E01),
    .fwd_req_o(rq), .fwd_valid_o(fv), .fwd_rsp_i(frs), .instr_tcm_privilege_out_o(itp),
    .data_tcm_privilege_out_o(dtp), .instr_tcm_debugger_flag_o(itf), .data_tcm_debugger_flag_o(dtf),
    .main_prot_o(mp), .main_cache_o(mc), .read_debugger_flag_o(rf), .write_debugger_flag_o(wf),
    .peripheral_port_protection_o(pa), .peripheral_port_debugger_flag_o(pf), .internal_private_peripheral_space_privileged_o(ipp),
    .internal_private_peripheral_space_debugger_bit_o(ipf), .psel_o(ps), .penable_o(pe), .pprot_o(pp), .apb_debugger_address_bit_o(ab),
    .pready_i(prdy), .prdata_i(prd), .pslverr_i(perr));

  dbar_tgt_model tgt (.clk_i(clk), .rst_i(rst), .fwd_valid_i(fv), .err_i(te), .fwd_rsp_o(frs),
    .psel_i(ps), .penable_i(pe), .pready_o(prdy), .prdata_o(prd), .pslverr_o(perr));

  // Snapshot attributes while a request is out; tally cache and main traffic
  always @(posedge clk) begin
    if (|fv || ps) begin
      sfl <= {ab, ipf, pf, rf, wf, dtf, itf};
      spa <= pa;
      smm <= {mp, mc};
      spp <= pp;
      stp <= {dtp, itp};
    end
    nm <= nm + int'(fv[2] & frs[2].ready);
    nl <= nl + int'(lk);
    nu <= nu + int'(up);
    nx <= nx + int'(mu);
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk

  // One transfer; request held until the ready edge, answer taken there
  task automatic xfer(input logic [31:0] a, input logic w, input logic [6:0] p, input logic n,
                      input logic [31:0] d, output logic e, output logic [31:0] q);
    logic e1;
    int k;
    e1 = 1'h0;
    k = 0;
    sel <= 1'h1;
    tr <= 2'h2;
    ad <= a;
    hw <= w;
    pr <= p;
    ns <= n;
    @(posedge clk);
    tr <= 2'h0;
    wd <= d;
    do begin
      @(negedge clk);
      e = rsp;
      q = hr;
      if (rdy !== 1'h1) e1 = rsp;
      k++;
    end while (rdy !== 1'h1 && k < 200);
    // A transfer that never completes is a failure in its own right
    if (rdy !== 1'h1) fails++;
    @(posedge clk);
    chk({31'h0, e1}, {31'h0, e});
  endtask : xfer

  // Flags f: {nonsecure request, error expected}
  task automatic get(input logic [31:0] a, input logic [6:0] p, input logic [1:0] f, input logic [31:0] x);
    logic e;
    logic [31:0] q;
    xfer(a, 1'h0, p, f[1], 32'h0, e, q);
    chk({31'h0, e}, {31'h0, f[0]});
    if (f[0] === 1'h0) chk(q, x);
  endtask : get

  task automatic put(input logic [31:0] a, input logic [6:0] p, input logic [1:0] f, input logic [31:0] d);
    logic e;
    logic [31:0] q;
    xfer(a, 1'h1, p, f[1], d, e, q);
    chk({31'h0, e}, {31'h0, f[0]});
  endtask : put

  // Register reset values and privilege on local registers
  task automatic t_regs();
    get(DEBUG_HALT_CONTROL_STATUS_ADDR, 7'h03, 2'h0, 32'h00010000);
    get(DEBUG_SECURITY_CONTROL_STATUS_ADDR, 7'h03, 2'h0, DEBUG_SECURITY_CONTROL_STATUS_RST);
    get(DEBUG_AUTHENTICATION_STATUS_ADDR, 7'h03, 2'h0, 32'h3);
    put(EXCEPTION_MONITOR_CONTROL_ADDR, 7'h03, 2'h0, 32'h01000F0F);
    get(EXCEPTION_MONITOR_CONTROL_ADDR, 7'h01, 2'h1, 32'h0);
    put(DEBUG_AUTHENTICATION_CONTROL_ADDR, 7'h03, 2'h0, 32'h00000001);
    get(EXCEPTION_MONITOR_CONTROL_ADDR, 7'h01, 2'h0, 32'h01000F0F);
  endtask : t_regs

  // Test windows stay Secure privileged even with the enable set
  task automatic t_apb();
    for (int i = 0; i < 3; i++) begin
      get({MEMTEST_PAGE + 20'(i), 12'h010}, 7'h01, 2'h1, 32'h0);
      get({MEMTEST_PAGE + 20'(i), 12'h010}, 7'h03, 2'h0, 32'hC0DE0001);
    end
    chk({22'h0, sfl, spp}, 32'h201);
    get(32'hE0050000, 7'h00, 2'h0, 32'hC0DE0001);
    put(DEBUG_AUTHENTICATION_CONTROL_ADDR, 7'h03, 2'h0, 32'h0);
    get(32'hE0050000, 7'h00, 2'h1, 32'h0);
    get(32'hE0050000, 7'h03, 2'h2, 32'hC0DE0001);
    chk({29'h0, spp}, 32'h3);
    get(32'hE0001000, 7'h7D, 2'h1, 32'h0);
    get(32'hE0001000, 7'h02, 2'h0, 32'hA5A50004);
    chk({25'h0, sfl}, 32'h20);
    chk({31'h0, ipp}, 32'h1);
  endtask : t_apb

  // Memories, main port and peripheral port attributes
  task automatic t_ports();
    get(32'h00000100, 7'h02, 2'h0, 32'hA5A50000);
    chk({23'h0, stp, sfl}, 32'h181);
    get(32'h20000040, 7'h01, 2'h0, 32'hA5A50001);
    chk({23'h0, stp[1], 1'h0, sfl}, 32'h02);
    get(32'h60000000, 7'h26, 2'h0, 32'hA5A50002);
    chk({18'h0, smm, sfl}, 32'h1C88);
    put(32'h60000000, 7'h25, 2'h2, 32'h12345678);
    chk({18'h0, smm, sfl}, 32'h1484);
    chk(rq.wdata, 32'h12345678);
    chk(la, 32'h60000000);
    get(32'h40001000, 7'h4A, 2'h0, 32'hA5A50003);
    chk({18'h0, spa, sfl}, 32'h2590);
  endtask : t_ports

  // Cache hit, write-through, miss and bypass
  task automatic t_cache();
    hit <= 1'h1;
    get(32'h60000010, 7'h1A, 2'h0, 32'h0CAC0E01);
    put(32'h60000010, 7'h1A, 2'h0, 32'h0000BEEF);
    put(32'h60000010, 7'h1E, 2'h0, 32'h0000BEEF);
    get(32'h60000010, 7'h5A, 2'h0, 32'hA5A50002);
    get(32'h00000200, 7'h1A, 2'h0, 32'hA5A50000);
    hit <= 1'h0;
    get(32'h60000010, 7'h1A, 2'h0, 32'hA5A50002);
    chk(32'(nm), 32'h5);
    chk(32'(nl), 32'h4);
    chk(32'(nu), 32'h2);
  endtask : t_cache

  // Attribution reject, unprivileged debug, target errors
  task automatic t_sec();
    security_attribution_unit <= 1'h1;
    get(32'h60000000, 7'h02, 2'h3, 32'h0);
    security_attribution_unit <= 1'h0;
    put(DEBUG_HALT_CONTROL_STATUS_ADDR, 7'h03, 2'h0, 32'h02000000);
    mpa <= 1'h0;
    get(32'h60000000, 7'h02, 2'h3, 32'h0);
    get(32'h60000000, 7'h02, 2'h0, 32'hA5A50002);
    chk({31'h0, ms}, 32'h1);
    mpa <= 1'h1;
    get(32'h60000000, 7'h02, 2'h2, 32'hA5A50002);
    chk({29'h0, smm[6:4]}, 32'h2);
    chk({31'h0, ms}, 32'h0);
    chk(32'(nx), 32'h2);
    put(DEBUG_HALT_CONTROL_STATUS_ADDR, 7'h03, 2'h0, 32'h0);
    te <= 1'h1;
    get(32'h00000100, 7'h02, 2'h1, 32'h0);
    get(32'hE0050000, 7'h03, 2'h1, 32'h0);
    te <= 1'h0;
    // Secure debug withdrawn; the pin needs two edges through the synchroniser
    sda <= 1'h0;
    repeat (2) @(posedge clk);
    get(DEBUG_HALT_CONTROL_STATUS_ADDR, 7'h03, 2'h0, 32'h0);
    security_attribution_unit <= 1'h1;
    get(32'h60000000, 7'h02, 2'h1, 32'h0);
    security_attribution_unit <= 1'h0;
  endtask : t_sec

  task automatic summarize();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  // Main sequence after a 16-cycle reset
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    t_regs();
    t_apb();
    t_ports();
    t_cache();
    t_sec();
    summarize();
  end

  // Watchdog: the run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    summarize();
  end
endmodule : debug_bus_access_router_tb_top
